// *** src/flash_map_pkg.sv ***
`default_nettype none

package flash_map_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Array geometry of the two variants
    localparam int LARGE_ARRAY_BYTES = 524288;
    localparam int SMALL_ARRAY_BYTES = 262144;
    localparam int PAGE_BYTES        = 256;
    localparam int SECTOR_BYTES      = 4096;
    localparam int BLOCK_BYTES       = 65536;
    localparam logic [23:0] SECTOR_OFFSET_MASK = 24'h000fff;
    localparam logic [23:0] BLOCK_OFFSET_MASK  = 24'h00ffff;

    ////////////////////////////////////////////////////////////////////////////
    // Security register space: index in bits 13:12, byte in bits 7:0
    localparam int SEC_REG_COUNT  = 4;
    localparam int SEC_REG_BYTES  = 256;
    localparam int SEC_SEL_MSB    = 13;
    localparam int SEC_SEL_LSB    = 12;
    localparam int SEC_BYTE_MSB   = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Discoverable-parameter space layout and contents
    localparam logic [7:0] PARAM_HEADER_BASE = 8'h00;
    localparam logic [7:0] PARAM_HEADER_RSVD = 8'h10;
    localparam logic [7:0] PARAM_TABLE_BASE  = 8'h30;
    localparam logic [7:0] PARAM_SPACE_END   = 8'h6f;
    localparam logic [7:0] PARAM_SIG0        = 8'h53;
    localparam logic [7:0] PARAM_SIG1        = 8'h46;
    localparam logic [7:0] PARAM_SIG2        = 8'h44;
    localparam logic [7:0] PARAM_SIG3        = 8'h50;
    localparam logic [7:0] ERASED_BYTE       = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes
    localparam logic [7:0] CMD_READ         = 8'h03;
    localparam logic [7:0] CMD_PROG         = 8'h02;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLOCK_ERASE  = 8'hd8;
    localparam logic [7:0] CMD_CHIP_ERASE   = 8'hc7;
    localparam logic [7:0] CMD_SEC_READ     = 8'h48;
    localparam logic [7:0] CMD_SEC_PROG     = 8'h42;
    localparam logic [7:0] CMD_SEC_ERASE    = 8'h44;
    localparam logic [7:0] CMD_PARAM_READ   = 8'h5a;

    ////////////////////////////////////////////////////////////////////////////
    // Frame lengths and timing
    localparam int CMD_BITS   = 8;
    localparam int ADDR_BITS  = 24;
    localparam int DUMMY_BITS = 8;
    localparam int CLOCK_NS             = 50;
    localparam int RESET_PULSE_MIN_TIME = 1000;
    localparam int RESET_CYCLES = (RESET_PULSE_MIN_TIME + CLOCK_NS - 1) / CLOCK_NS;

endpackage

`default_nettype wire

// *** src/flash_cell_mem.sv ***
`default_nettype none

// Byte storage with registered read; starts erased
module flash_cell_mem #(
    parameter int DEPTH = 525056,
    parameter int WIDTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic             clock,
    // Read port
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data
);

    // Fresh part reads as all ones; set by the declaration so only one process writes
    logic [WIDTH-1:0] cells [DEPTH] = '{default: {WIDTH{1'b1}}};

    // Registered read, plain write
    always_ff @(posedge clock) begin
        rd_data <= cells[rd_addr];
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

endmodule

`default_nettype wire

// *** src/serial_flash_map_and_reset.sv ***
`default_nettype none

module serial_flash_map_and_reset #(
    parameter int ARRAY_BYTES = flash_map_pkg::LARGE_ARRAY_BYTES
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Serial bus pins
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       data_in,
    output logic            data_out,
    output logic            data_oe,
    input  wire logic       data_line_three_in,
    // Configuration bits
    input  wire logic       quad_lane_enable_bit,
    input  wire logic       pause_or_reset_pin_select,
    input  wire logic [3:0] sec_lock_bits,
    // Status
    output logic            busy
);

    localparam int ARR_AW    = $clog2(ARRAY_BYTES);
    localparam int MEM_DEPTH = ARRAY_BYTES + (flash_map_pkg::SEC_REG_COUNT - 1)
                               * flash_map_pkg::SEC_REG_BYTES;
    localparam int MEM_AW    = $clog2(MEM_DEPTH);
    localparam int RCW       = $clog2(flash_map_pkg::RESET_CYCLES + 1);
    localparam int RST_WAIT  = flash_map_pkg::RESET_CYCLES;

    // Only the two documented array sizes are served
    if (ARRAY_BYTES != flash_map_pkg::LARGE_ARRAY_BYTES &&
        ARRAY_BYTES != flash_map_pkg::SMALL_ARRAY_BYTES) begin : g_bad_size
        $error("ARRAY_BYTES must be one of the two variant sizes");
    end

    typedef enum logic [3:0] {
        st_idle, st_cmd, st_addr, st_dummy, st_read, st_prog, st_ignore, st_go_erase, st_erase
    } phase_e;

    typedef struct packed {
        logic              cs_s1;
        logic              cs_s2;
        logic              ck_s1;
        logic              ck_s2;
        logic              ck_d;
        logic              di_s1;
        logic              di_s2;
        logic              rp_s1;
        logic              rp_s2;
        phase_e            phase;
        logic              armed;
        logic [RCW-1:0]    rst_cnt;
        logic [7:0]        cmd;
        logic [7:0]        rx;
        logic [7:0]        tx;
        logic [7:0]        pdata;
        logic [7:0]        wdata;
        logic [4:0]        bits;
        logic [23:0]       addr;
        logic              load;
        logic              so;
        logic              oe;
        logic              busy;
        logic              pstep;
        logic              we;
        logic [MEM_AW-1:0] raddr;
        logic [MEM_AW-1:0] waddr;
        logic [ARR_AW:0]   ecnt;
    } state_s;

    state_s     st_reg;
    state_s     st_next;
    logic [7:0] rd_data;
    logic       pin_is_reset;
    logic       pause;
    logic       rst_act;
    logic       rise;
    logic       fall;
    logic       cs_hi;
    logic       sec_cmd;
    logic       use_param;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Array bytes first, then security registers 1 to 3
    function automatic logic [MEM_AW-1:0] map_addr(input logic sec, input logic [23:0] a);
        logic [MEM_AW-1:0] m;
        m = '0;
        if (sec) begin
            m = MEM_AW'(ARRAY_BYTES) + MEM_AW'({a[flash_map_pkg::SEC_SEL_MSB:
                flash_map_pkg::SEC_SEL_LSB] - 2'h1, a[flash_map_pkg::SEC_BYTE_MSB:0]});
        end else begin
            m = MEM_AW'(a[ARR_AW-1:0]);
        end
        return m;
    endfunction

    // Register 0 and locked registers take no program or erase
    function automatic logic sec_writable(input logic [23:0] a);
        logic [1:0] idx;
        idx = a[flash_map_pkg::SEC_SEL_MSB:flash_map_pkg::SEC_SEL_LSB];
        return (idx != 2'h0) && !sec_lock_bits[idx];
    endfunction

    // Factory parameter contents; unlisted bytes read erased
    function automatic logic [7:0] param_byte(input logic [7:0] a);
        logic [7:0] b;
        b = flash_map_pkg::ERASED_BYTE;
        unique case (a)
            flash_map_pkg::PARAM_HEADER_BASE:        b = flash_map_pkg::PARAM_SIG0;
            flash_map_pkg::PARAM_HEADER_BASE + 8'h1: b = flash_map_pkg::PARAM_SIG1;
            flash_map_pkg::PARAM_HEADER_BASE + 8'h2: b = flash_map_pkg::PARAM_SIG2;
            flash_map_pkg::PARAM_HEADER_BASE + 8'h3: b = flash_map_pkg::PARAM_SIG3;
            default:                                 b = flash_map_pkg::ERASED_BYTE;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decoded conditions from configuration bits and registered state
    assign pin_is_reset = pause_or_reset_pin_select && !quad_lane_enable_bit;
    assign pause   = !quad_lane_enable_bit && !pause_or_reset_pin_select
                     && !st_reg.rp_s2 && !st_reg.cs_s2;
    assign rst_act = st_reg.rst_cnt == RCW'(RST_WAIT);
    assign rise    = st_reg.ck_s2 && !st_reg.ck_d;
    assign fall    = !st_reg.ck_s2 && st_reg.ck_d;
    assign cs_hi   = st_reg.cs_s2;
    assign sec_cmd = st_reg.cmd == flash_map_pkg::CMD_SEC_READ
                     || st_reg.cmd == flash_map_pkg::CMD_SEC_PROG
                     || st_reg.cmd == flash_map_pkg::CMD_SEC_ERASE;
    assign use_param = st_reg.cmd == flash_map_pkg::CMD_PARAM_READ
                       || (st_reg.cmd == flash_map_pkg::CMD_SEC_READ
                       && st_reg.addr[flash_map_pkg::SEC_SEL_MSB:
                          flash_map_pkg::SEC_SEL_LSB] == 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next       = st_reg;
        st_next.we    = 1'b0;
        st_next.load  = 1'b0;
        st_next.pstep = 1'b0;
        st_next.cs_s1 = cs_n;
        st_next.cs_s2 = st_reg.cs_s1;
        st_next.ck_s1 = sclk;
        st_next.ck_s2 = st_reg.ck_s1;
        st_next.ck_d  = st_reg.ck_s2;
        st_next.di_s1 = data_in;
        st_next.di_s2 = st_reg.di_s1;
        st_next.rp_s1 = data_line_three_in;
        st_next.rp_s2 = st_reg.rp_s1;
        // Reset pin low time, saturating
        if (pin_is_reset && !st_reg.rp_s2) begin
            if (!rst_act) begin
                st_next.rst_cnt = st_reg.rst_cnt + 1'b1;
            end
        end else begin
            st_next.rst_cnt = '0;
        end
        // Read data lands one cycle after the address
        if (st_reg.load) begin
            st_next.tx = use_param ? param_byte(st_reg.addr[7:0]) : rd_data;
        end
        // Second half of program: merge can only clear bits
        if (st_reg.pstep) begin
            st_next.we    = 1'b1;
            st_next.waddr = st_reg.raddr;
            st_next.wdata = rd_data & st_reg.pdata;
        end
        if (rst_act) begin
            st_next.phase = st_idle;
            st_next.armed = 1'b0;
            st_next.busy  = 1'b0;
            st_next.oe    = 1'b0;
        end else if (st_reg.phase == st_erase) begin
            if (st_reg.ecnt == (ARR_AW+1)'(1)) begin
                st_next.phase = st_idle;
                st_next.busy  = 1'b0;
            end else begin
                st_next.we    = 1'b1;
                st_next.waddr = st_reg.waddr + 1'b1;
                st_next.ecnt  = st_reg.ecnt - 1'b1;
            end
        end else if (cs_hi) begin
            st_next.armed = 1'b1;
            st_next.oe    = 1'b0;
            st_next.phase = st_idle;
            if (st_reg.phase == st_go_erase) begin
                st_next.wdata = flash_map_pkg::ERASED_BYTE;
                st_next.phase = st_erase;
                st_next.busy  = 1'b1;
                st_next.we    = 1'b1;
                // Only sector, block, chip and register sized erases exist
                unique case (st_reg.cmd)
                    flash_map_pkg::CMD_CHIP_ERASE: begin
                        st_next.waddr = '0;
                        st_next.ecnt  = (ARR_AW+1)'(ARRAY_BYTES);
                    end
                    flash_map_pkg::CMD_SECTOR_ERASE: begin
                        st_next.waddr = map_addr(1'b0,
                            st_reg.addr & ~flash_map_pkg::SECTOR_OFFSET_MASK);
                        st_next.ecnt  = (ARR_AW+1)'(flash_map_pkg::SECTOR_BYTES);
                    end
                    flash_map_pkg::CMD_BLOCK_ERASE: begin
                        st_next.waddr = map_addr(1'b0,
                            st_reg.addr & ~flash_map_pkg::BLOCK_OFFSET_MASK);
                        st_next.ecnt  = (ARR_AW+1)'(flash_map_pkg::BLOCK_BYTES);
                    end
                    default: begin
                        st_next.waddr = map_addr(1'b1, st_reg.addr);
                        st_next.ecnt  = (ARR_AW+1)'(flash_map_pkg::SEC_REG_BYTES);
                        if (!sec_writable(st_reg.addr)) begin
                            st_next.phase = st_idle;
                            st_next.busy  = 1'b0;
                            st_next.we    = 1'b0;
                        end
                    end
                endcase
            end
        end else if (st_reg.phase == st_idle) begin
            if (st_reg.armed) begin
                st_next.phase = st_cmd;
                st_next.armed = 1'b0;
                st_next.bits  = '0;
            end
        end else if (pause) begin
            st_next.oe = 1'b0;
        end else if (rise) begin
            st_next.rx   = {st_reg.rx[6:0], st_reg.di_s2};
            st_next.bits = st_reg.bits + 1'b1;
            unique case (st_reg.phase)
                st_cmd: if (st_reg.bits == 5'(flash_map_pkg::CMD_BITS - 1)) begin
                    st_next.cmd   = st_next.rx;
                    st_next.bits  = '0;
                    st_next.phase = st_ignore;
                    if (st_next.rx == flash_map_pkg::CMD_CHIP_ERASE) begin
                        st_next.phase = st_go_erase;
                    end else if (st_next.rx inside {flash_map_pkg::CMD_READ,
                        flash_map_pkg::CMD_PROG, flash_map_pkg::CMD_SECTOR_ERASE,
                        flash_map_pkg::CMD_BLOCK_ERASE, flash_map_pkg::CMD_SEC_READ,
                        flash_map_pkg::CMD_SEC_PROG, flash_map_pkg::CMD_SEC_ERASE,
                        flash_map_pkg::CMD_PARAM_READ}) begin
                        st_next.phase = st_addr;
                    end
                end
                st_addr: begin
                    st_next.addr = {st_reg.addr[22:0], st_reg.di_s2};
                    if (st_reg.bits == 5'(flash_map_pkg::ADDR_BITS - 1)) begin
                        st_next.bits = '0;
                        unique case (st_reg.cmd)
                            flash_map_pkg::CMD_READ: begin
                                st_next.phase = st_read;
                                st_next.raddr = map_addr(1'b0, st_next.addr);
                                st_next.load  = 1'b1;
                            end
                            flash_map_pkg::CMD_SEC_READ,
                            flash_map_pkg::CMD_PARAM_READ: st_next.phase = st_dummy;
                            flash_map_pkg::CMD_PROG:       st_next.phase = st_prog;
                            flash_map_pkg::CMD_SEC_PROG:
                                st_next.phase = sec_writable(st_next.addr)
                                                ? st_prog : st_ignore;
                            default:                       st_next.phase = st_go_erase;
                        endcase
                    end
                end
                st_dummy: if (st_reg.bits == 5'(flash_map_pkg::DUMMY_BITS - 1)) begin
                    st_next.bits  = '0;
                    st_next.phase = st_read;
                    st_next.raddr = map_addr(sec_cmd, st_reg.addr);
                    st_next.load  = 1'b1;
                end
                st_read: if (st_reg.bits == 5'd7) begin
                    st_next.bits = '0;
                    // Array reads run on through the array; register reads wrap
                    st_next.addr = (st_reg.cmd == flash_map_pkg::CMD_READ)
                        ? st_reg.addr + 24'h1
                        : {st_reg.addr[23:8], st_reg.addr[7:0] + 8'h1};
                    st_next.raddr = map_addr(sec_cmd, st_next.addr);
                    st_next.load  = 1'b1;
                end
                st_prog: if (st_reg.bits == 5'd7) begin
                    st_next.bits  = '0;
                    st_next.pdata = st_next.rx;
                    st_next.raddr = map_addr(sec_cmd, st_reg.addr);
                    st_next.pstep = 1'b1;
                    // Byte address wraps inside the page
                    st_next.addr  = {st_reg.addr[23:8], st_reg.addr[7:0] + 8'h1};
                end
                default: ;
            endcase
        end else if (fall && st_reg.phase == st_read) begin
            st_next.so = st_reg.tx[7];
            st_next.tx = {st_reg.tx[6:0], 1'b0};
            st_next.oe = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_reg       <= '0;
            st_reg.cs_s1 <= 1'b1;
            st_reg.cs_s2 <= 1'b1;
            st_reg.rp_s1 <= 1'b1;
            st_reg.rp_s2 <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign data_out = st_reg.so;
    assign data_oe  = st_reg.oe;
    assign busy     = st_reg.busy;

    // Array and security register storage
    flash_cell_mem #(
        .DEPTH (MEM_DEPTH),
        .WIDTH (8)
    ) u_cells (
        .clock   (clock),
        .rd_addr (st_next.raddr),
        .rd_data (rd_data),
        .wr_en   (st_reg.we),
        .wr_addr (st_reg.waddr),
        .wr_data (st_reg.wdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_reset_gating: assert property (!pin_is_reset |=> st_reg.rst_cnt == '0)
        else $error("reset counter ran while pin is not a reset");
    a_quad_no_reset: assert property (
        quad_lane_enable_bit && $past(quad_lane_enable_bit) |-> !rst_act && !pause)
        else $error("line three acted as control in quad mode");
    a_reset_low_time: assert property (
        $rose(rst_act) |-> $past(st_reg.rp_s2, RST_WAIT) == 1'b0 && !st_reg.rp_s2)
        else $error("reset taken before the minimum low time");
    a_reset_aborts: assert property (
        rst_act |=> st_reg.phase == st_idle && !st_reg.busy && !st_reg.oe)
        else $error("reset did not abort the operation");
    a_rearm_needed: assert property (
        st_reg.phase == st_idle && !st_reg.armed && !cs_hi |=> st_reg.phase != st_cmd)
        else $error("command started without chip select cycling");
    a_prog_clears: assert property (
        $past(st_reg.pstep) |-> st_reg.we && (st_reg.wdata & ~$past(rd_data)) == 8'h0)
        else $error("program set a bit");
    a_erase_sizes: assert property (
        $rose(st_reg.busy) |-> st_reg.ecnt == (ARR_AW+1)'(flash_map_pkg::SECTOR_BYTES)
        || st_reg.ecnt == (ARR_AW+1)'(flash_map_pkg::BLOCK_BYTES)
        || st_reg.ecnt == (ARR_AW+1)'(ARRAY_BYTES)
        || (sec_cmd && st_reg.ecnt == (ARR_AW+1)'(flash_map_pkg::SEC_REG_BYTES)))
        else $error("erase of an unsupported size");
    a_sector_align: assert property (
        $rose(st_reg.busy) && st_reg.cmd == flash_map_pkg::CMD_SECTOR_ERASE
        |-> (st_reg.waddr & MEM_AW'(flash_map_pkg::SECTOR_OFFSET_MASK)) == '0)
        else $error("sector erase not aligned");
    a_locked_erase: assert property (
        st_reg.phase == st_go_erase && cs_hi && st_reg.cmd == flash_map_pkg::CMD_SEC_ERASE
        && !sec_writable(st_reg.addr) |=> st_reg.phase == st_idle && !st_reg.we)
        else $error("locked or parameter register erased");
    a_mem_bound: assert property (st_reg.we |-> st_reg.waddr < MEM_AW'(MEM_DEPTH))
        else $error("write beyond storage");
    a_param_source: assert property (
        st_reg.load && st_reg.cmd == flash_map_pkg::CMD_PARAM_READ
        |=> st_reg.tx == param_byte($past(st_reg.addr[7:0])))
        else $error("parameter read took wrong data");

endmodule

`default_nettype wire

// *** testbench/host_model.sv ***
`default_nettype none
// Host side of the serial bus, mode 0, four clocks per half bit
module host_model (
    // Clock
    input  wire logic clock,
    // Bus pins
    output var logic  cs_n,
    output var logic  sclk,
    output var logic  data_in,
    input  wire logic data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle: deselected, clock low and still
    initial begin
        cs_n = 1;
        sclk = 0;
        data_in = 0;
    end
    // One bit each way, sampled late in the high phase
    task automatic bit_io(input logic b, output logic q);
        data_in = b;
        repeat (4) @(negedge clock);
        sclk = 1;
        repeat (4) @(negedge clock);
        q = data_out;
        sclk = 0;
    endtask
    task automatic xbyte(input logic [7:0] b, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_io(b[i], q[i]);
    endtask
    task automatic open_frame();
        cs_n = 0;
        repeat (4) @(negedge clock);
    endtask
    // Released data line shows the inverse of its last value
    task automatic close_frame();
        repeat (4) @(negedge clock);
        cs_n = 1;
        data_in = ~data_in;
        repeat (8) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// *** testbench/test_serial_flash_map_and_reset.sv ***
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module test_serial_flash_map_and_reset;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int S = 32'h1000000; // Model key base of the security space
    logic       clock = 0, resetn = 0, line3 = 1, quad = 0, sel = 0;
    logic       cs_n, sclk, data_in, data_out, data_oe, busy;
    logic [3:0] locks = 4'h4;
    logic [7:0] r, mem [int];
    int         failures = 0, n_tests = 0, a, pa;
    always #25 clock = ~clock;
    host_model u_host (.clock, .cs_n, .sclk, .data_in, .data_out);
    serial_flash_map_and_reset #(.ARRAY_BYTES(flash_map_pkg::SMALL_ARRAY_BYTES)) u_dut (
        .clock, .resetn, .cs_n, .sclk, .data_in, .data_out, .data_oe,
        .data_line_three_in(line3), .quad_lane_enable_bit(quad),
        .pause_or_reset_pin_select(sel), .sec_lock_bits(locks), .busy);
    function automatic logic [7:0] ev(int k);
        return mem.exists(k) ? mem[k] : 8'hff;
    endfunction
    task automatic end_sim();
        if (failures == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 70000 && busy !== 1'b0; i++) @(negedge clock);
        if (busy !== 1'b0) begin
            failures++;
            end_sim();
        end
    endtask
    // Command, address and dummy bytes
    task automatic head(logic [7:0] c, int ad, int nd);
        u_host.open_frame();
        u_host.xbyte(c, r);
        for (int k = 2; k >= 0; k--) u_host.xbyte(ad[8*k+:8], r);
        repeat (nd) u_host.xbyte(8'h00, r);
    endtask
    task automatic rd(logic [7:0] c, int ad, int n, int k);
        head(c, ad, (c == flash_map_pkg::CMD_READ) ? 0 : 1);
        for (int i = 0; i < n; i++) begin
            u_host.xbyte(8'h00, r);
            `CHK("read byte", ev(k + i), r)
            `CHK("data enable", 1'b1, data_oe)
        end
        u_host.close_frame();
    endtask
    // Random program; bytes wrap in the page and only cleared bits stick
    task automatic wr(logic [7:0] c, int ad, int n, int pg, bit ok);
        logic [7:0] b;
        head(c, ad, 0);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            u_host.xbyte(b, r);
            if (ok) mem[pg + ((ad + i) & 255)] = ev(pg + ((ad + i) & 255)) & b;
        end
        u_host.close_frame();
        wait_idle();
    endtask
    task automatic erase(logic [7:0] c, int ad, int n, int base);
        head(c, ad, 0);
        u_host.close_frame();
        for (int j = 0; j < n; j++) mem.delete(base + j);
        wait_idle();
    endtask
    // Main sequence
    initial begin
        void'($urandom(93284));
        repeat (2) @(negedge clock);
        resetn = 1;
        repeat (4) @(negedge clock);
        mem[S] = 8'h53;
        mem[S + 1] = 8'h46;
        mem[S + 2] = 8'h44;
        mem[S + 3] = 8'h50;
        rd(flash_map_pkg::CMD_PARAM_READ, 0, 4, S);
        rd(flash_map_pkg::CMD_PARAM_READ, 'h6e, 4, S + 'h6e);
        pa = ($urandom % 1008) * 256;
        for (int p = 0; p < 3; p++) begin
            a = (p == 0) ? pa : (p == 1) ? 'h3ff00 : 'h3ef00;
            repeat (2) wr(flash_map_pkg::CMD_PROG, a + 'hf0, 32, a, 1);
            rd(flash_map_pkg::CMD_READ, a, 16, a);
        end
        erase(flash_map_pkg::CMD_SECTOR_ERASE, 'h3f123, 4096, 'h3f000);
        rd(flash_map_pkg::CMD_READ, 'h3eff0, 32, 'h3eff0);
        rd(flash_map_pkg::CMD_READ, pa + 'hf0, 16, pa + 'hf0);
        for (int n = 0; n < 4; n++)
            wr(flash_map_pkg::CMD_SEC_PROG, n * 'h1000 + 'h10, 8, S + n * 'h1000, n[0]);
        erase(flash_map_pkg::CMD_SEC_ERASE, 'h3000, 256, S + 'h3000);
        for (int n = 0; n < 4; n++)
            rd(flash_map_pkg::CMD_SEC_READ, n * 'h1000, 32, S + n * 'h1000);
        // Pin reset in the middle of a block erase, frame left open
        head(flash_map_pkg::CMD_BLOCK_ERASE, 0, 0);
        u_host.close_frame();
        u_host.open_frame();
        line3 = 0;
        quad = 1;
        sel = 1;
        repeat (40) @(negedge clock);
        `CHK("busy", 1'b1, busy)
        quad = 0;
        sel = 0;
        repeat (40) @(negedge clock);
        `CHK("busy", 1'b1, busy)
        sel = 1;
        repeat (40) @(negedge clock);
        `CHK("busy", 1'b0, busy)
        line3 = 1;
        for (int i = 0; i < 6; i++) u_host.xbyte(i ? 8'h00 : 8'h5a, r);
        `CHK("data enable", 1'b0, data_oe)
        u_host.close_frame();
        rd(flash_map_pkg::CMD_PARAM_READ, 0, 4, S);
        end_sim();
    end
endmodule
`default_nettype wire
